// ---- fcb_map.vh ----
/*
  Named constants for the configuration-at-reset flag buffer.
  Assumes it is included by its bare name from the design file.
*/
`ifndef FCB_MAP_VH
`define FCB_MAP_VH

// Positions of the configuration bits in the captured code.
`define FCB_CFG_FL   2
`define FCB_CFG_RX   1
`define FCB_CFG_WX   0
`define FCB_CFG_W    3
`define FCB_CFG_RST  3'h0

// Register-buffering depths, as stage counts.
`define FCB_BUF_SINGLE 2'h1
`define FCB_BUF_DOUBLE 2'h2
`define FCB_BUF_TRIPLE 2'h3
`define FCB_BUF_W      2
`define FCB_STAGES     3

// Documented depth and default partial-flag offsets.
`define FCB_DEPTH      512
`define FCB_ADDR_W     9
`define FCB_AE_OFFSET  63
`define FCB_AF_OFFSET  63

// Reset values of single-bit state.
`define FCB_ZERO 1'h0
`define FCB_ONE  1'h1

`endif

// ---- fcb_peer.sv ----
/* Writer and reader model for the far side of the flag buffer.
   Assumes one clock for both sides; each word written is its own index. */
module fcb_peer (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire [17:0] n_words_i,
  input  wire        stall_i,
  input  wire        wr_ready_i,
  input  wire        rd_valid_i,
  input  wire [17:0] rd_data_i,
  output wire        wr_valid_o,
  output reg  [17:0] wr_data_o,
  output wire        rd_ready_o,
  output reg  [17:0] rd_cnt_o,
  output reg  [17:0] rd_last_o
);
  reg taken;
  // The writer holds each word until the edge that takes it; the reader never pops an empty head.
  assign wr_valid_o = wr_data_o < n_words_i;
  assign rd_ready_o = rd_valid_i && !stall_i;
  // Take and pop are seen at the rising edge.
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      taken    <= 1'b0;
      rd_cnt_o <= 18'h0;
      rd_last_o <= 18'h0;
    end
    else
    begin
      taken <= wr_valid_o && wr_ready_i;
      if (rd_ready_o)
      begin
        rd_cnt_o  <= rd_cnt_o + 18'h1;
        rd_last_o <= rd_data_i;
      end
    end
  // The next word is offered only after the taking edge has passed.
  always @(negedge clk_i or negedge nrst_i)
    if (!nrst_i)
      wr_data_o <= 18'h0;
    else if (taken)
      wr_data_o <= wr_data_o + 18'h1;
endmodule // fcb_peer

// ---- fcb_props.sv ----
/* Checker for the flag buffer, watching only the ports of fcb_top.
   Assumes ce_i held high and the configuration pins static while words move. */
module fcb_props #(
  parameter DEPTH     = 8,
  parameter AE_OFFSET = 2,
  parameter AF_OFFSET = 2
) (
  input wire clk_i,
  input wire nrst_i,
  input wire first_load_select_i,
  input wire read_chain_in_i,
  input wire write_chain_in_i,
  input wire output_enable_n_i,
  input wire wr_valid_i,
  input wire wr_ready_o,
  input wire rd_valid_o,
  input wire rd_ready_i,
  input wire data_oe_o,
  input wire empty_flag_n_o,
  input wire full_flag_n_o,
  input wire almost_empty_n_o,
  input wire almost_full_n_o,
  input wire fall_through_mode_o
);
  reg  [7:0] occ;
  reg  [2:0] rc;
  wire       ft  = !read_chain_in_i && write_chain_in_i;
  wire       dbl = read_chain_in_i && !write_chain_in_i;
  wire       syn = first_load_select_i && !(read_chain_in_i && write_chain_in_i);
  wire       put = wr_valid_i && wr_ready_o;
  wire       pop = rd_valid_o && rd_ready_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Words held, counted from the handshakes, and edges since reset release.
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      occ <= 8'h00;
      rc  <= 3'h0;
    end
    else
    begin
      occ <= occ + {7'h00, put} - {7'h00, pop};
      rc  <= (rc == 3'h7) ? rc : rc + 3'h1;
    end
  a_oe_sync: assert property ($changed(output_enable_n_i) ##1 $stable(output_enable_n_i) [*2]
    |-> data_oe_o == !output_enable_n_i) else $error("drive enable lag");
  a_empty_single: assert property (!ft && !dbl && put && occ == 8'h00
    |-> ##1 !empty_flag_n_o ##1 empty_flag_n_o) else $error("single empty release");
  a_empty_double: assert property (dbl && put && occ == 8'h00
    |-> ##1 !empty_flag_n_o [*2] ##1 empty_flag_n_o) else $error("double empty release");
  a_ready_triple: assert property (ft && put && occ == 8'h00
    |-> ##1 empty_flag_n_o [*3] ##1 !empty_flag_n_o) else $error("triple ready");
  a_full_release: assert property (!ft && !dbl && pop && !full_flag_n_o
    |-> ##2 full_flag_n_o) else $error("full release");
  a_ae_async: assert property (!syn |-> almost_empty_n_o == (occ > AE_OFFSET))
    else $error("async almost empty");
  a_af_sync: assert property (syn |-> almost_full_n_o == ($past(occ) < DEPTH - AF_OFFSET))
    else $error("sync almost full");
  a_mode_held: assert property (rc == 3'h7 |-> $stable(fall_through_mode_o))
    else $error("mode changed");
endmodule // fcb_props
bind fcb_top fcb_props #(.DEPTH(DEPTH), .AE_OFFSET(AE_OFFSET), .AF_OFFSET(AF_OFFSET)) i_fcb_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .first_load_select_i(first_load_select_i),
  .read_chain_in_i(read_chain_in_i), .write_chain_in_i(write_chain_in_i),
  .output_enable_n_i(output_enable_n_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
  .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .data_oe_o(data_oe_o),
  .empty_flag_n_o(empty_flag_n_o), .full_flag_n_o(full_flag_n_o), .almost_empty_n_o(almost_empty_n_o),
  .almost_full_n_o(almost_full_n_o), .fall_through_mode_o(fall_through_mode_o));

// ---- fcb_top.v ----
/*
  Configuration-at-reset decoder with boundary-flag buffering around a word store,
  a two-entry output buffer and partial flags.
  Assumes configuration, output-enable pins come from outside the clock domain and
  that write and read sides share clk_i; the parties keep the chain wiring themselves.
*/
`include "fcb_map.vh"

module fcb_top #(
  parameter DATA_W    = 18,
  parameter DEPTH     = `FCB_DEPTH,
  parameter ADDR_W    = `FCB_ADDR_W,
  parameter AE_OFFSET = `FCB_AE_OFFSET,
  parameter AF_OFFSET = `FCB_AF_OFFSET
) (
  input  wire              clk_i,
  input  wire              nrst_i,
  input  wire              ce_i,
  input  wire              first_load_select_i,
  input  wire              read_chain_in_i,
  input  wire              write_chain_in_i,
  input  wire              output_enable_n_i,
  input  wire              wr_valid_i,
  input  wire [DATA_W-1:0] wr_data_i,
  output wire              wr_ready_o,
  output wire              rd_valid_o,
  input  wire              rd_ready_i,
  output wire [DATA_W-1:0] data_out_o,
  output wire              data_oe_o,
  output wire              empty_flag_n_o,
  output wire              full_flag_n_o,
  output wire              almost_empty_n_o,
  output wire              almost_full_n_o,
  output wire              fall_through_mode_o,
  output wire              chain_member_o,
  output reg               read_chain_out_o,
  output reg               write_chain_out_o
);

  // Integer forms first, so that each sized constant taken from them below is a deliberate slice.
  localparam integer      DEPTH_I  = DEPTH;
  localparam integer      LAST_I   = DEPTH - 1;
  localparam integer      AE_I     = AE_OFFSET;
  localparam integer      AF_I     = DEPTH - AF_OFFSET;
  localparam [ADDR_W:0]   DEPTH_C  = DEPTH_I[ADDR_W:0];
  localparam [ADDR_W:0]   AE_LIM   = AE_I[ADDR_W:0];
  localparam [ADDR_W:0]   AF_LIM   = AF_I[ADDR_W:0];
  localparam [ADDR_W-1:0] LAST_A   = LAST_I[ADDR_W-1:0];
  localparam [ADDR_W:0]   ONE_C    = {{ADDR_W{1'b0}}, 1'b1};
  localparam [ADDR_W:0]   CNT_ZERO = {(ADDR_W+1){1'b0}};

  reg  [`FCB_CFG_W-1:0] cfg_s1;
  reg  [`FCB_CFG_W-1:0] cfg_s2;
  reg  [`FCB_CFG_W-1:0] cfg;
  reg                   oe_s1;
  reg                   oe_s2;
  reg                   rel_s1;
  reg                   rel_s2;
  reg                   running;
  reg                   ir_armed;
  reg  [DATA_W-1:0]     mem [0:DEPTH-1];
  reg  [ADDR_W-1:0]     wr_ptr;
  reg  [ADDR_W-1:0]     rd_ptr;
  reg  [ADDR_W:0]       count;
  reg  [DATA_W-1:0]     buf0;
  reg  [DATA_W-1:0]     buf1;
  reg                   bv0;
  reg                   bv1;
  reg  [`FCB_STAGES-1:0] empty_pipe;
  reg  [`FCB_STAGES-1:0] full_pipe;
  reg                   ae_reg;
  reg                   af_reg;
  reg                   fall_through_mode;
  reg                   sync_partial;
  reg  [`FCB_BUF_W-1:0] empty_depth;
  reg  [`FCB_BUF_W-1:0] full_depth;

  wire [ADDR_W:0] total = count + {{(ADDR_W-1){1'b0}}, bv0 & bv1, bv0 ^ bv1};
  wire raw_empty = (total == CNT_ZERO);
  wire raw_full  = (total >= DEPTH_C);
  wire ae_now    = (total <= AE_LIM);
  wire af_now    = (total >= AF_LIM);
  wire push_wr   = wr_valid_i & wr_ready_o;
  wire pop_out   = rd_valid_o & rd_ready_i; // No pop while the empty flag still reads empty.
  wire buf_push  = running & (count != CNT_ZERO) & ~bv1;

  // Configuration pins and output enable pass two flops before use.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_s1  <= `FCB_CFG_RST;
      cfg_s2  <= `FCB_CFG_RST;
      oe_s1   <= `FCB_ONE;
      oe_s2   <= `FCB_ONE;
      rel_s1  <= `FCB_ZERO;
      rel_s2  <= `FCB_ZERO;
      running <= `FCB_ZERO;
    end
    else if (ce_i)
    begin
      cfg_s1  <= {first_load_select_i, read_chain_in_i, write_chain_in_i};
      cfg_s2  <= cfg_s1;
      oe_s1   <= output_enable_n_i;
      oe_s2   <= oe_s1;
      rel_s1  <= `FCB_ONE;
      rel_s2  <= rel_s1;
      running <= rel_s2;
    end
  end

  // The code is sampled until reset has fully left the block, then frozen.
  // The release pipe is one flop longer than the pin synchroniser, so the last capture sees the pins.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cfg <= `FCB_CFG_RST;
    else if (ce_i && !running)
      cfg <= cfg_s2;
  end

  // Decode of the captured code into timing, buffering and partial-flag mode.
  always @*
  begin
    fall_through_mode         = ~cfg[`FCB_CFG_RX] & cfg[`FCB_CFG_WX];
    sync_partial = cfg[`FCB_CFG_FL] & ~(cfg[`FCB_CFG_RX] & cfg[`FCB_CFG_WX]);
    empty_depth  = `FCB_BUF_SINGLE;
    full_depth   = `FCB_BUF_SINGLE;
    if (fall_through_mode)
    begin
      empty_depth = `FCB_BUF_TRIPLE;
      full_depth  = `FCB_BUF_DOUBLE;
    end
    else if (cfg[`FCB_CFG_RX] && !cfg[`FCB_CFG_WX])
    begin
      empty_depth = `FCB_BUF_DOUBLE;
      full_depth  = `FCB_BUF_DOUBLE;
    end
  end

  // Write and read pointers of the word store and the occupancy count.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr <= {ADDR_W{1'b0}};
      rd_ptr <= {ADDR_W{1'b0}};
      count  <= CNT_ZERO;
    end
    else if (ce_i)
    begin
      if (push_wr)
        wr_ptr <= (wr_ptr == LAST_A) ? {ADDR_W{1'b0}} : wr_ptr + 1'b1;
      if (buf_push)
        rd_ptr <= (rd_ptr == LAST_A) ? {ADDR_W{1'b0}} : rd_ptr + 1'b1;
      if (push_wr && !buf_push)
        count <= count + ONE_C;
      else if (!push_wr && buf_push)
        count <= count - ONE_C;
    end
  end

  // Storage array has no reset; only written words are ever read.
  always @(posedge clk_i)
  begin
    if (ce_i && push_wr)
      mem[wr_ptr] <= wr_data_i;
  end

  // Two-entry output buffer: a stalled reader loses no word.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      buf0 <= {DATA_W{1'b0}};
      buf1 <= {DATA_W{1'b0}};
      bv0  <= `FCB_ZERO;
      bv1  <= `FCB_ZERO;
    end
    else if (ce_i)
    begin
      if (pop_out)
      begin
        if (bv1)
        begin
          buf0 <= buf1;
          if (buf_push)
            buf1 <= mem[rd_ptr];
          bv1 <= buf_push;
        end
        else
        begin
          if (buf_push)
            buf0 <= mem[rd_ptr];
          bv0 <= buf_push;
        end
      end
      else if (buf_push)
      begin
        if (!bv0)
        begin
          buf0 <= mem[rd_ptr];
          bv0  <= `FCB_ONE;
        end
        else
        begin
          buf1 <= mem[rd_ptr];
          bv1  <= `FCB_ONE;
        end
      end
    end
  end

  // Boundary-flag synchroniser chains; the tap is chosen by the configured depth.
  genvar gi;
  generate
    for (gi = 0; gi < `FCB_STAGES; gi = gi + 1)
    begin : g_stage
      always @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          empty_pipe[gi] <= `FCB_ONE;
          full_pipe[gi]  <= `FCB_ZERO;
        end
        else if (ce_i)
        begin
          empty_pipe[gi] <= (gi == 0) ? raw_empty : empty_pipe[(gi == 0) ? 0 : gi - 1];
          full_pipe[gi]  <= (gi == 0) ? raw_full : full_pipe[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  wire empty_tap = empty_pipe[empty_depth - 1'b1];
  wire full_tap  = full_pipe[full_depth - 1'b1];

  // Partial flags, registered copy for synchronous mode, and chain pulses.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ae_reg            <= `FCB_ONE;
      af_reg            <= `FCB_ZERO;
      ir_armed          <= `FCB_ZERO;
      read_chain_out_o  <= `FCB_ZERO;
      write_chain_out_o <= `FCB_ZERO;
    end
    else if (ce_i)
    begin
      ae_reg            <= ae_now;
      af_reg            <= af_now;
      ir_armed          <= running;
      write_chain_out_o <= push_wr & (total == DEPTH_C - ONE_C) & ~pop_out;
      read_chain_out_o  <= pop_out & (total == ONE_C) & ~push_wr;
    end
  end

  // Both sides share clk_i, so the crossing degenerates to the same-clock case.
  assign wr_ready_o          = running & (count < DEPTH_C) & ~full_tap;
  assign rd_valid_o          = bv0 & ~empty_tap;
  assign data_out_o          = buf0;
  assign data_oe_o           = ~oe_s2;
  assign empty_flag_n_o      = fall_through_mode ? empty_tap : ~empty_tap;
  assign full_flag_n_o       = fall_through_mode ? (~ir_armed | full_tap) : ~full_tap;
  assign almost_empty_n_o    = ~(sync_partial ? ae_reg : ae_now);
  assign almost_full_n_o     = ~(sync_partial ? af_reg : af_now);
  assign fall_through_mode_o = fall_through_mode;
  assign chain_member_o      = cfg[`FCB_CFG_RX] & cfg[`FCB_CFG_WX];

endmodule // fcb_top

// ---- fcb_top_bench.sv ----
/* Self-checking bench for the flag buffer with an eight-word store.
   Assumes fcb_peer as far side and the bound checker fcb_props. */
module fcb_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk_i = 1'b0;
  reg         nrst_i = 1'b0;
  reg  [2:0]  cfg = 3'h0;
  reg         oe_n = 1'b1;
  reg         stall = 1'b1;
  reg  [17:0] n_words = 18'h0;
  wire        wv, wr, rv, rr, oe, ef, ff, ae, af, ftm, chm, read_chain_out, write_chain_out;
  int         n_rxo = 0;
  int         n_wxo = 0;
  wire [17:0] wd, dq, rcnt, rlast;
  int         fail_count = 0;
  int         n_checks = 0;
  logic [2:0] modes [8] = '{3'h0, 3'h2, 3'h1, 3'h5, 3'h6, 3'h7, 3'h4, 3'h3};
  always #4 clk_i = ~clk_i;
  fcb_top #(.DEPTH(8), .ADDR_W(3), .AE_OFFSET(2), .AF_OFFSET(2)) i_fcb_top (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .first_load_select_i(cfg[2]),
    .read_chain_in_i(cfg[1]), .write_chain_in_i(cfg[0]), .output_enable_n_i(oe_n),
    .wr_valid_i(wv), .wr_data_i(wd), .wr_ready_o(wr), .rd_valid_o(rv), .rd_ready_i(rr),
    .data_out_o(dq), .data_oe_o(oe), .empty_flag_n_o(ef), .full_flag_n_o(ff),
    .almost_empty_n_o(ae), .almost_full_n_o(af), .fall_through_mode_o(ftm),
    .chain_member_o(chm), .read_chain_out_o(read_chain_out), .write_chain_out_o(write_chain_out));
  fcb_peer i_fcb_peer (
    .clk_i(clk_i), .nrst_i(nrst_i), .n_words_i(n_words), .stall_i(stall), .wr_ready_i(wr),
    .rd_valid_i(rv), .rd_data_i(dq), .wr_valid_o(wv), .wr_data_o(wd), .rd_ready_o(rr),
    .rd_cnt_o(rcnt), .rd_last_o(rlast));
  // Chain pulses are counted per run, so a pulse that stands too long counts twice.
  always @(posedge clk_i)
    if (!nrst_i)
    begin
      n_rxo <= 0;
      n_wxo <= 0;
    end
    else
    begin
      n_rxo <= n_rxo + read_chain_out;
      n_wxo <= n_wxo + write_chain_out;
    end
  task check(input [17:0] seen, input [17:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Reset for 12 cycles with a listed code on static pins.
  task restart(input [2:0] code);
    @(negedge clk_i);
    nrst_i = 1'b0;
    cfg = code;
    n_words = 18'h0;
    stall = 1'b1;
    repeat (12) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask
  // Every code decodes to its timing mode, chain role and reset flags.
  task t_codes;
    for (int c = 0; c < 8; c++)
    begin
      restart(c[2:0]);
      check(ftm, c[1:0] == 2'b01);
      check(chm, c[1:0] == 2'b11);
      check(ff, c[1:0] != 2'b01);
      check(ae, 1'b0);
      check(dq, 18'h0);
    end
  endtask
  // Fill until refused with the reader stalled, then drain to empty.
  task t_stream(input [2:0] code);
    restart(code);
    n_words = 18'h8;
    repeat (30) @(negedge clk_i);
    check(wr, 1'b0);
    check(wd, 18'h8);
    check(ff, code[1:0] == 2'b01);
    check(af, 1'b0);
    check(ae, 1'b1);
    check(n_wxo[17:0], 18'h1);
    check(n_rxo[17:0], 18'h0);
    stall = 1'b0;
    repeat (30) @(negedge clk_i);
    check(rcnt, 18'h8);
    check(rlast, 18'h7);
    check(rv, 1'b0);
    check(ef, code[1:0] == 2'b01);
    check(n_rxo[17:0], 18'h1);
  endtask
  // Drive enable follows its pin; the captured mode ignores later pin changes.
  task t_pins;
    restart(3'h0);
    oe_n = 1'b0;
    repeat (3) @(negedge clk_i);
    check(oe, 1'b1);
    oe_n = 1'b1;
    cfg = 3'h3;
    repeat (3) @(negedge clk_i);
    check(oe, 1'b0);
    check(chm, 1'b0);
  endtask
  initial
  begin
    t_codes;
    foreach (modes[i])
      t_stream(modes[i]);
    t_pins;
    report_and_stop;
  end
  // Watchdog well past the expected run of about 800 cycles.
  initial
  begin
    #40000;
    fail_count++;
    report_and_stop;
  end
endmodule // fcb_top_bench
